//--- serial_link_pkg.sv
// constants for the module-side serial link with sleep handshake
// assumes a 10 MHz core clock
package serial_link_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned BAUD = 115200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BITS = 1;
	// wake pulse, roughly 10 us, longest time rounds down
	localparam int unsigned WAKE_PULSE_US = 10;
	localparam int unsigned WAKE_PULSE_CYCLES = (WAKE_PULSE_US * (CLK_HZ / 1000000));
	// least low time that counts as a wake request from the host
	localparam int unsigned WAKE_MIN_US = 10;
	localparam int unsigned WAKE_MIN_CYCLES = (WAKE_MIN_US * (CLK_HZ / 1000000));
	// boot indicator timing
	localparam int unsigned BOOT_GREEN_MS = 1000;
	localparam int unsigned BOOT_GREEN_CYCLES_DEF = BOOT_GREEN_MS * (CLK_HZ / 1000);
	localparam int unsigned BOOT_BLINK_MS = 100;
	localparam int unsigned BOOT_BLINK_CYCLES_DEF = BOOT_BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned ALT_BLINK_MS = 250;
	localparam int unsigned ALT_BLINK_CYCLES_DEF = ALT_BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [7:0] INDICATOR_OFF_ARG = 8'h00;
	typedef enum logic [1:0] {
		BOOT_LIT,
		BOOT_BLINK,
		BOOT_DONE
	} boot_state_e;
endpackage

//--- byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, read data registered
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("byte_fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;
	logic full;
	logic empty;
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign in_ready_o = !full;
	// output stage is a register; refill whenever it is free
	assign pop = !empty && (!out_valid_o || out_ready_i);
	assign push = in_valid_i && !full;
	always_ff @(posedge core_clk_i) begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(1);
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + (AW + 1)'(1);
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o <= mem_reg[rd_ptr_reg[AW-1:0]];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule

//--- host_serial_sleep_handshake.sv
// module-side serial link: uart transmit/receive, sleep handshake lines and indicators
// assumes all inputs synchronous to core_clk_i and open-drain pins resolved outside
//
// How it works
// - 115200 bit/s, eight data, no parity
// - wake host with roughly 10 us low
// - module ready open-drain, low while active
// - module drives ready low after waking
// - never send to a sleeping peer
// - ready high selects the bootloader, sampled after reset
// - host ready high means host sleeping
// - boot: green one second, then both blink
// - green lit while receiving
// - red lit while transmitting
// - bootloader blinks green and red alternately
// - indicator command zero disables both indicators
module host_serial_sleep_handshake
	import serial_link_pkg::*;
#(
	parameter int unsigned BOOT_GREEN_CYCLES = serial_link_pkg::BOOT_GREEN_CYCLES_DEF,
	parameter int unsigned BOOT_BLINK_CYCLES = serial_link_pkg::BOOT_BLINK_CYCLES_DEF,
	parameter int unsigned ALT_BLINK_CYCLES = serial_link_pkg::ALT_BLINK_CYCLES_DEF
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// serial pins
	input wire logic rxd_i,
	output logic txd_o,
	// host-ready line, open drain, driven only for the wake pulse
	input wire logic host_ready_n_i,
	output logic host_ready_n_o,
	output logic host_ready_n_oe_o,
	// module-ready line, open drain
	input wire logic module_ready_n_i,
	output logic module_ready_n_o,
	output logic module_ready_n_oe_o,
	// radio controller side
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_frame_err_o,
	input wire logic sleep_req_i,
	input wire logic wake_host_i,
	output logic awake_o,
	output logic host_awake_o,
	output logic bootloader_o,
	input wire logic radio_rx_mode_i,
	input wire logic radio_tx_mode_i,
	input wire logic indicator_cmd_i,
	input wire logic [7:0] indicator_arg_i,
	output logic led_green_o,
	output logic led_red_o
);
	import serial_link_pkg::*;

	initial begin
		if (BOOT_GREEN_CYCLES < 1 || BOOT_BLINK_CYCLES < 1 || ALT_BLINK_CYCLES < 1)
			$error("indicator timing counts must be at least one");
	end

	localparam int BW = $clog2(BIT_CYCLES + 1);
	localparam int LW = 32;

	// ==========================================================
	// sleep handshake
	logic awake_reg;
	logic strap_done_reg;
	logic [7:0] wake_low_cnt_reg;
	logic [7:0] host_pulse_cnt_reg;
	logic host_awake;

	assign host_awake = !host_ready_n_i;

	// strap caught by a clocked process on the first edge after release
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_done_reg <= 1'b0;
			bootloader_o <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			bootloader_o <= module_ready_n_i;
		end
	end

	// we stay asleep until the host holds our line low long enough
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			awake_reg <= 1'b0;
			wake_low_cnt_reg <= '0;
		end else if (awake_reg) begin
			wake_low_cnt_reg <= '0;
			if (sleep_req_i)
				awake_reg <= 1'b0;
		end else if (!module_ready_n_i) begin
			if (wake_low_cnt_reg >= 8'(WAKE_MIN_CYCLES - 1))
				awake_reg <= 1'b1;
			else
				wake_low_cnt_reg <= wake_low_cnt_reg + 8'h01;
		end else begin
			wake_low_cnt_reg <= '0;
		end
	end

	// drive module-ready low only while active, float otherwise
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			module_ready_n_o <= 1'b0;
			module_ready_n_oe_o <= 1'b0;
		end else begin
			module_ready_n_o <= 1'b0;
			module_ready_n_oe_o <= awake_reg && !sleep_req_i;
		end
	end

	// wake pulse to the host, only when it shows sleep
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			host_pulse_cnt_reg <= '0;
			host_ready_n_o <= 1'b0;
			host_ready_n_oe_o <= 1'b0;
		end else begin
			host_ready_n_o <= 1'b0;
			if (host_pulse_cnt_reg != 8'h00) begin
				host_pulse_cnt_reg <= host_pulse_cnt_reg - 8'h01;
				host_ready_n_oe_o <= (host_pulse_cnt_reg != 8'h01);
			end else if (wake_host_i && !host_awake && awake_reg) begin
				host_pulse_cnt_reg <= 8'(WAKE_PULSE_CYCLES);
				host_ready_n_oe_o <= 1'b1;
			end else begin
				host_ready_n_oe_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			awake_o <= 1'b0;
			host_awake_o <= 1'b0;
		end else begin
			awake_o <= awake_reg;
			host_awake_o <= host_awake && (host_pulse_cnt_reg == 8'h00);
		end
	end

	// ==========================================================
	// transmit path through the fifo
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_take;
	logic fifo_in_ready;
	logic tx_busy_reg;
	logic [BW-1:0] tx_tick_reg;
	logic [3:0] tx_bit_reg;
	logic [9:0] tx_shift_reg;

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) tx_fifo (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.in_data_i(tx_data_i),
		.in_valid_i(tx_valid_i && tx_ready_o),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_take)
	);

	// a sleeping party sends nothing, and nothing goes to a sleeping host
	assign fifo_take = !tx_busy_reg && awake_reg && host_awake && host_pulse_cnt_reg == 8'h00;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tx_ready_o <= 1'b0;
		else
			tx_ready_o <= fifo_in_ready && !(tx_valid_i && tx_ready_o);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_busy_reg <= 1'b0;
			tx_tick_reg <= '0;
			tx_bit_reg <= '0;
			tx_shift_reg <= '1;
			txd_o <= 1'b1;
		end else if (!tx_busy_reg) begin
			txd_o <= 1'b1;
			if (fifo_valid && fifo_take) begin
				// stop, eight data lsb first, start; no parity
				tx_shift_reg <= {1'b1, fifo_data, 1'b0};
				tx_busy_reg <= 1'b1;
				tx_tick_reg <= '0;
				tx_bit_reg <= '0;
			end
		end else begin
			txd_o <= tx_shift_reg[0];
			if (tx_tick_reg == BW'(BIT_CYCLES - 1)) begin
				tx_tick_reg <= '0;
				tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
				if (tx_bit_reg == 4'(DATA_BITS + STOP_BITS))
					tx_busy_reg <= 1'b0;
				else
					tx_bit_reg <= tx_bit_reg + 4'h1;
			end else begin
				tx_tick_reg <= tx_tick_reg + BW'(1);
			end
		end
	end

	// ==========================================================
	// receive path
	logic rx_busy_reg;
	logic [BW-1:0] rx_tick_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_busy_reg <= 1'b0;
			rx_tick_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= '0;
			rx_data_o <= '0;
			rx_valid_o <= 1'b0;
			rx_frame_err_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			rx_frame_err_o <= 1'b0;
			if (!rx_busy_reg) begin
				// asleep we cannot receive
				if (!rxd_i && awake_reg) begin
					rx_busy_reg <= 1'b1;
					rx_tick_reg <= BW'(BIT_CYCLES / 2);
					rx_bit_reg <= '0;
				end
			end else if (rx_tick_reg == BW'(BIT_CYCLES - 1)) begin
				rx_tick_reg <= '0;
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0) begin
					// false start: glitch shorter than half a bit
					if (rxd_i)
						rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg <= 4'(DATA_BITS)) begin
					rx_shift_reg <= {rxd_i, rx_shift_reg[7:1]};
				end else begin
					rx_busy_reg <= 1'b0;
					rx_data_o <= rx_shift_reg;
					rx_valid_o <= rxd_i;
					rx_frame_err_o <= !rxd_i;
				end
			end else begin
				rx_tick_reg <= rx_tick_reg + BW'(1);
			end
		end
	end

	// ==========================================================
	// indicators
	boot_state_e boot_state_reg;
	logic [LW-1:0] boot_cnt_reg;
	logic [LW-1:0] alt_cnt_reg;
	logic alt_phase_reg;
	logic leds_enabled_reg;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			leds_enabled_reg <= 1'b1;
		else if (indicator_cmd_i)
			leds_enabled_reg <= (indicator_arg_i != INDICATOR_OFF_ARG);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_state_reg <= BOOT_LIT;
			boot_cnt_reg <= '0;
		end else begin
			unique case (boot_state_reg)
				BOOT_LIT: begin
					if (boot_cnt_reg == LW'(BOOT_GREEN_CYCLES - 1)) begin
						boot_cnt_reg <= '0;
						boot_state_reg <= BOOT_BLINK;
					end else begin
						boot_cnt_reg <= boot_cnt_reg + LW'(1);
					end
				end
				BOOT_BLINK: begin
					if (boot_cnt_reg == LW'(BOOT_BLINK_CYCLES - 1))
						boot_state_reg <= BOOT_DONE;
					else
						boot_cnt_reg <= boot_cnt_reg + LW'(1);
				end
				BOOT_DONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			alt_cnt_reg <= '0;
			alt_phase_reg <= 1'b0;
		end else if (alt_cnt_reg == LW'(ALT_BLINK_CYCLES - 1)) begin
			alt_cnt_reg <= '0;
			alt_phase_reg <= !alt_phase_reg;
		end else begin
			alt_cnt_reg <= alt_cnt_reg + LW'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			led_green_o <= 1'b0;
			led_red_o <= 1'b0;
		end else if (!leds_enabled_reg) begin
			led_green_o <= 1'b0;
			led_red_o <= 1'b0;
		end else if (boot_state_reg == BOOT_LIT) begin
			led_green_o <= 1'b1;
			led_red_o <= 1'b0;
		end else if (boot_state_reg == BOOT_BLINK) begin
			led_green_o <= 1'b1;
			led_red_o <= 1'b1;
		end else if (bootloader_o) begin
			led_green_o <= alt_phase_reg;
			led_red_o <= !alt_phase_reg;
		end else begin
			led_green_o <= radio_rx_mode_i;
			led_red_o <= radio_tx_mode_i;
		end
	end
endmodule

//--- host_serial_sleep_handshake_sva.sv
// checker for the serial link's handshake lines and indicators
// assumes one clock domain and the small boot counts of the bench
module link_sva
	import serial_link_pkg::*;
#(
	parameter int unsigned BOOT_GREEN_CYCLES = 20,
	parameter int unsigned BOOT_BLINK_CYCLES = 5
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic host_ready_n_i,
	input wire logic host_ready_n_o,
	input wire logic host_ready_n_oe_o,
	input wire logic module_ready_n_i,
	input wire logic module_ready_n_o,
	input wire logic module_ready_n_oe_o,
	input wire logic rx_valid_o,
	input wire logic wake_host_i,
	input wire logic awake_o,
	input wire logic bootloader_o,
	input wire logic radio_rx_mode_i,
	input wire logic radio_tx_mode_i,
	input wire logic indicator_cmd_i,
	input wire logic [7:0] indicator_arg_i,
	input wire logic led_green_o,
	input wire logic led_red_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned G = BOOT_GREEN_CYCLES;
	localparam int unsigned B = BOOT_BLINK_CYCLES;
	logic [7:0] pulse_cnt;
	logic [7:0] low_cnt;
	logic [7:0] up_cnt;
	logic led_en;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ==========================================
	// helper counters
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) pulse_cnt <= 8'h00;
		else pulse_cnt <= host_ready_n_oe_o ? pulse_cnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) low_cnt <= 8'h00;
		else if (module_ready_n_i) low_cnt <= 8'h00;
		else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) up_cnt <= 8'h00;
		else if (up_cnt != 8'hff) up_cnt <= up_cnt + 8'h01;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) led_en <= 1'b1;
		else if (indicator_cmd_i) led_en <= (indicator_arg_i != INDICATOR_OFF_ARG);
	end
	// ==========================================
	// assertions
	AST_OD_LOW: assert property ((host_ready_n_oe_o || module_ready_n_oe_o) |->
		!host_ready_n_o && !module_ready_n_o) else $error("open drain drives high");
	AST_WAKE_MAX: assert property (host_ready_n_oe_o |-> pulse_cnt < 8'h64)
		else $error("wake pulse too long");
	AST_WAKE_LEN: assert property ($fell(host_ready_n_oe_o) |-> pulse_cnt == 8'h64)
		else $error("wake pulse length wrong");
	AST_WAKE_CAUSE: assert property ($rose(host_ready_n_oe_o) |->
		$past(host_ready_n_i) && $past(wake_host_i)) else $error("wake pulse uncalled");
	AST_AWAKE_CAUSE: assert property ($rose(awake_o) |-> $past(low_cnt, 2) >= 8'h62)
		else $error("woke without request");
	AST_READY_AWAKE: assert property (module_ready_n_oe_o |-> awake_o)
		else $error("ready low while asleep");
	AST_RX_AWAKE: assert property (rx_valid_o |-> awake_o)
		else $error("byte received while asleep");
	AST_BOOT_GREEN: assert property ((up_cnt >= 2 && up_cnt < G) |->
		led_green_o && !led_red_o) else $error("boot green wrong");
	AST_BOOT_BLINK: assert property ((up_cnt > G + 1 && up_cnt < G + B) |->
		led_green_o && led_red_o) else $error("boot blink wrong");
	AST_MODE_LEDS: assert property ((up_cnt > G + B + 2 && !bootloader_o && led_en
		&& $past(led_en)) |-> led_green_o == $past(radio_rx_mode_i)
		&& led_red_o == $past(radio_tx_mode_i)) else $error("mode leds wrong");
	AST_LEDS_OFF: assert property ((!led_en && !$past(led_en)) |->
		!led_green_o && !led_red_o) else $error("leds not off");
	AST_ALTERNATE: assert property ((up_cnt > G + B + 2 && bootloader_o && led_en
		&& $past(led_en)) |-> led_green_o != led_red_o) else $error("no alternation");
	AST_STRAP_HOLD: assert property (up_cnt > 2 |-> $stable(bootloader_o))
		else $error("strap changed");
	COV_WAKE_HOST: cover property ($fell(host_ready_n_oe_o));
	COV_AWAKE: cover property ($rose(awake_o));
	COV_RX: cover property (rx_valid_o);
endmodule

bind host_serial_sleep_handshake link_sva #(
	.BOOT_GREEN_CYCLES(BOOT_GREEN_CYCLES),
	.BOOT_BLINK_CYCLES(BOOT_BLINK_CYCLES)
) u_link_sva (.core_clk_i, .arst_n_i, .host_ready_n_i, .host_ready_n_o, .host_ready_n_oe_o,
	.module_ready_n_i, .module_ready_n_o, .module_ready_n_oe_o, .rx_valid_o, .wake_host_i,
	.awake_o, .bootloader_o, .radio_rx_mode_i, .radio_tx_mode_i, .indicator_cmd_i,
	.indicator_arg_i, .led_green_o, .led_red_o);

//--- app_host_model.sv
// application host: serial framing and its own ready line
// assumes the bench resolves the open-drain wires with pull-ups
module app_host_model
	import serial_link_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic txd_i,
	input wire logic host_ready_wire_i,
	input wire logic sleep_i,
	output logic rxd_o,
	output logic host_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wake_seen;
	initial begin
		rxd_o = 1'b1;
		host_low_o = 1'b1;
		wake_seen = 1'b0;
	end
	// asleep the line is an interrupt; wake once the pulse has ended
	always @(posedge core_clk_i) begin
		if (sleep_i) host_low_o <= 1'b0;
		else if (!host_low_o && !host_ready_wire_i) wake_seen <= 1'b1;
		else if (wake_seen && host_ready_wire_i) begin
			host_low_o <= 1'b1;
			wake_seen <= 1'b0;
		end
	end
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk_i);
			rxd_o <= f[i];
			repeat (BIT_CYCLES - 1) @(posedge core_clk_i);
		end
	endtask
	// returns stop bit over data; all zero when no frame came
	task automatic recv_byte(output logic [8:0] got);
		int n;
		n = 0;
		got = 9'h000;
		while (txd_i !== 1'b0 && n < 20000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n < 20000) begin
			repeat (BIT_CYCLES / 2) @(posedge core_clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYCLES) @(posedge core_clk_i);
				got[i] = txd_i;
			end
		end
	endtask
endmodule

//--- test_host_serial_sleep_handshake.sv
// self-checking bench for the module-side serial link
// assumes the checker is bound and the host model sits on the far side
module test_host_serial_sleep_handshake;
	timeunit 1ns;
	timeprecision 1ns;
	import serial_link_pkg::*;
	logic clk, arst_n, rxd, txd, hr_o, hr_oe, mr_o, mr_oe, host_low, mod_low, hr_w, mr_w;
	logic tx_valid, tx_ready, rx_valid, rx_err, sleep_req, wake_host, awake, host_awake;
	logic boot, rxm, txm, icmd, green, red, host_sleep, acc;
	logic [7:0] tx_data, rx_data, iarg, rx_last, b;
	logic [8:0] got;
	logic [7:0] exp_q[$];
	int mismatches, n_tests, cyc, errs, n_rx;
	// ==========================================
	// wires with pull-ups
	assign hr_w = ~(host_low | (hr_oe & ~hr_o));
	assign mr_w = ~(mod_low | (mr_oe & ~mr_o));
	host_serial_sleep_handshake #(.BOOT_GREEN_CYCLES(20), .BOOT_BLINK_CYCLES(5),
		.ALT_BLINK_CYCLES(4)) u_host_serial_sleep_handshake (.core_clk_i(clk),
		.arst_n_i(arst_n), .rxd_i(rxd), .txd_o(txd), .host_ready_n_i(hr_w),
		.host_ready_n_o(hr_o), .host_ready_n_oe_o(hr_oe), .module_ready_n_i(mr_w),
		.module_ready_n_o(mr_o), .module_ready_n_oe_o(mr_oe), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_frame_err_o(rx_err), .sleep_req_i(sleep_req),
		.wake_host_i(wake_host), .awake_o(awake), .host_awake_o(host_awake),
		.bootloader_o(boot), .radio_rx_mode_i(rxm), .radio_tx_mode_i(txm),
		.indicator_cmd_i(icmd), .indicator_arg_i(iarg), .led_green_o(green),
		.led_red_o(red));
	app_host_model u_app_host_model (.core_clk_i(clk), .txd_i(txd), .host_ready_wire_i(hr_w),
		.sleep_i(host_sleep), .rxd_o(rxd), .host_low_o(host_low));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [8:0] frame_of(input logic [7:0] d);
		return {1'b1, d};
	endfunction
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rx_last <= rx_data;
			n_rx++;
		end
		if (rx_err === 1'b1) errs++;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		{arst_n, tx_valid, sleep_req, wake_host, rxm, txm, icmd, host_sleep} = '0;
		{tx_data, iarg} = '0;
		mod_low = 1'b1;
		void'($urandom(32'hd28a));
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		#1 check("boot leds", 9'h002, {green, red});
		check("strap", 9'h000, boot);
		repeat (150) @(posedge clk);
		mod_low <= 1'b0;
		host_sleep <= 1'b1;
		@(posedge clk);
		host_sleep <= 1'b0;
		#1 check("awake", 9'h003, {awake, mr_oe});
		// host asleep: bytes stay queued until the fifo refuses
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_data <= 8'($urandom);
		repeat (12) begin
			// ready read settled, half a period before the edge that takes the byte
			@(negedge clk);
			acc = tx_ready;
			@(posedge clk);
			if (acc === 1'b1) begin
				exp_q.push_back(tx_data);
				tx_data <= 8'($urandom);
			end
		end
		tx_valid <= 1'b0;
		// the fifo's registered output stage holds one byte beyond its memory
		check("fifo fill", 9'(FIFO_DEPTH + 1), 9'(exp_q.size()));
		check("idle txd", 9'h001, txd);
		wake_host <= 1'b1;
		@(posedge clk);
		wake_host <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check("wake pulse", 9'h001, hr_oe);
		foreach (exp_q[i]) begin
			u_app_host_model.recv_byte(got);
			check("tx byte", frame_of(exp_q[i]), got);
		end
		check("host awake", 9'h001, host_awake);
		for (int i = 0; i < 5; i++) begin
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			u_app_host_model.send_byte(b);
			@(posedge clk);
			check("rx byte", b, rx_last);
			check("rx count", 9'(i + 1), 9'(n_rx));
		end
		check("frame errors", 9'h000, 9'(errs));
		repeat (12) begin
			@(posedge clk);
			rxm <= 1'($urandom);
			txm <= 1'($urandom);
			repeat (2) @(posedge clk);
			#1 check("mode leds", {rxm, txm}, {green, red});
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			icmd <= 1'b1;
			iarg <= (i == 0) ? INDICATOR_OFF_ARG : 8'($urandom) | 8'h01;
			rxm <= 1'b1;
			txm <= 1'b1;
			@(posedge clk);
			icmd <= 1'b0;
			repeat (3) @(posedge clk);
			#1 check("indicator cmd", (i == 0) ? 9'h000 : 9'h003, {green, red});
		end
		// module sleeps, then the host wakes it again by holding the line low
		@(posedge clk);
		sleep_req <= 1'b1;
		repeat (2) @(posedge clk);
		#1 check("asleep", 9'h000, {awake, mr_oe});
		@(posedge clk);
		sleep_req <= 1'b0;
		mod_low <= 1'b1;
		repeat (WAKE_MIN_CYCLES + 3) @(posedge clk);
		#1 check("rewake", 9'h003, {awake, mr_oe});
		@(posedge clk);
		mod_low <= 1'b0;
		// second reset with the strap line floating high
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (60) @(posedge clk);
		#1 check("bootloader", 9'h001, boot);
		check("alternate", 9'h001, green ^ red);
		close_out();
	end
endmodule
